/* File: core/lsm_lane_mapper.v */
// sample-to-lane transport packer for the 9-bit converter, formats 11 to 14.
// assumes samples arrive one frame at a time with a one-cycle strobe and that
// the link layer after it does line coding per the coding flag.
//
// How it works
// - format 11: 9-bit, 8 or 4 lanes, 8B/10B
// - format 11: five samples, three zeros, tail nibble
// - format 12: one 8-bit octet per lane, 64B/66B
// - format 13: four samples plus one zero bit
// - format 14: two samples, even/odd split per lane
// - format 14: B on 2-3, C/D on 4-7
`timescale 1ns/1ps
`include "lsm_consts.vh"

module lsm_lane_mapper #(
  parameter [3:0] TAIL_BITS = 4'h0
) (
  // clock and reset
  input  wire         SYS_CLK_IN,
  input  wire         NRST_IN,
  // configuration
  input  wire [3:0]   FORMAT_SEL_IN,
  input  wire [1:0]   VARIANT_IN,
  input  wire         LINK_EN_IN,
  // sample frame
  input  wire         FRAME_VALID_IN,
  input  wire [179:0] CHAN_A_IN,
  input  wire [179:0] CHAN_B_IN,
  input  wire [35:0]  CHAN_C_IN,
  input  wire [35:0]  CHAN_D_IN,
  // lane frames
  output wire [511:0] LANE_DATA_OUT,
  output reg          LANE_VALID_OUT,
  output reg  [7:0]   LANE_EN_OUT,
  output reg  [3:0]   OCTETS_OUT,
  output reg          CODING_64B66B_OUT,
  output reg          CFG_ERROR_OUT,
  output reg  [3:0]   FORMAT_ACTIVE_OUT
);

  reg  [3:0]   link_format_select;
  reg  [1:0]   variant;
  reg  [7:0]   next_lane_en;
  reg  [3:0]   next_octets;
  reg          next_coding;
  reg          next_error;
  wire         frame_take;

  // sample n of a channel bus sits at bits n*9 +: 9
  function [8:0] smp;
    input [179:0] bus;
    input [4:0]   idx;
    begin
      smp = bus[idx * `LSM_SMP_W +: `LSM_SMP_W];
    end
  endfunction

  // format and variant only follow the inputs while the link is down
  always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      link_format_select <= `LSM_FMT_RESET;
      variant            <= `LSM_VAR_RESET;
    end else if (!LINK_EN_IN) begin
      link_format_select <= FORMAT_SEL_IN;
      variant            <= VARIANT_IN;
    end
  end

  // lane usage, frame length and coding per format and variant
  always @* begin
    next_lane_en = `LSM_MASK_NONE;
    next_octets  = `LSM_OCT_11;
    next_coding  = 1'b0;
    next_error   = 1'b0;
    case (link_format_select)
      `LSM_FMT_11: begin
        next_octets = `LSM_OCT_11;
        next_coding = 1'b0;
        if (variant == `LSM_VAR_DUAL) begin
          next_lane_en = `LSM_MASK_8;
        end else if (variant == `LSM_VAR_SINGLE) begin
          next_lane_en = `LSM_MASK_4;
        end else begin
          next_error = 1'b1;
        end
      end
      `LSM_FMT_12: begin
        next_octets = `LSM_OCT_12;
        next_coding = 1'b1;
        if (variant == `LSM_VAR_DUAL) begin
          next_lane_en = `LSM_MASK_8;
        end else if (variant == `LSM_VAR_SINGLE) begin
          next_lane_en = `LSM_MASK_4;
        end else begin
          next_error = 1'b1;
        end
      end
      `LSM_FMT_13: begin
        next_octets = `LSM_OCT_13;
        next_coding = 1'b0;
        if (variant == `LSM_VAR_DUAL) begin
          next_lane_en = `LSM_MASK_8;
        end else if (variant == `LSM_VAR_SINGLE) begin
          next_lane_en = `LSM_MASK_4;
        end else begin
          next_error = 1'b1;
        end
      end
      `LSM_FMT_14: begin
        next_octets = `LSM_OCT_14;
        next_coding = 1'b1;
        if (variant == `LSM_VAR_QUAD) begin
          next_lane_en = `LSM_MASK_8;
        end else if (variant == `LSM_VAR_DUAL) begin
          next_lane_en = `LSM_MASK_4;
        end else if (variant == `LSM_VAR_SINGLE) begin
          next_lane_en = `LSM_MASK_2;
        end else begin
          next_error = 1'b1;
        end
      end
      default: begin
        next_error = 1'b1;
      end
    endcase
  end

  // a frame is packed only with a live link and a legal setup
  // the error term is the live decode, so a refused setup never launches
  // a frame even in the cycle before CFG_ERROR_OUT shows it
  assign frame_take = FRAME_VALID_IN && LINK_EN_IN && !next_error;

  // status flops
  // status lags the latched setup by one edge; raise the link only after
  // the setup inputs have been steady for two edges
  always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      LANE_VALID_OUT    <= 1'b0;
      LANE_EN_OUT       <= `LSM_MASK_NONE;
      OCTETS_OUT        <= `LSM_OCT_11;
      CODING_64B66B_OUT <= 1'b0;
      CFG_ERROR_OUT     <= 1'b0;
      FORMAT_ACTIVE_OUT <= `LSM_FMT_RESET;
    end else begin
      LANE_VALID_OUT    <= frame_take;
      LANE_EN_OUT       <= next_lane_en;
      OCTETS_OUT        <= next_octets;
      CODING_64B66B_OUT <= next_coding;
      CFG_ERROR_OUT     <= next_error;
      FORMAT_ACTIVE_OUT <= link_format_select;
    end
  end

  // one packer per lane; lane frame is msb first, octet 0 in bits 63:56
  genvar g;
  generate
    for (g = 0; g < `LSM_NUM_LANES; g = g + 1) begin : lane
      localparam integer KI  = g % 4;
      localparam integer PI  = g % 2;
      localparam [4:0]   K   = KI[4:0];
      localparam [4:0]   P14 = PI[4:0];
      reg  [63:0]  word;
      reg  [63:0]  next_word;
      // formats 11-13: lanes 0-3 take A, lanes 4-7 take B
      wire [179:0] src_ab = (g < 4) ? CHAN_A_IN : CHAN_B_IN;
      // format 14: each lane pair takes one channel
      wire [179:0] src_14 = (g < 2) ? CHAN_A_IN :
                            (g < 4) ? CHAN_B_IN :
                            (g < 6) ? {144'h0, CHAN_C_IN} : {144'h0, CHAN_D_IN};
      // format 12: the 8-bit sample is the top eight bits of the 9-bit slot
      wire [8:0]   head_smp = smp(src_ab, K);

      // lane frame contents for the active format
      always @* begin
        next_word = 64'h0;
        case (link_format_select)
          `LSM_FMT_11: begin
            next_word = {smp(src_ab, K),         3'h0,
                         smp(src_ab, K + 5'h04), 3'h0,
                         smp(src_ab, K + 5'h08), 3'h0,
                         smp(src_ab, K + 5'h0C), 3'h0,
                         smp(src_ab, K + 5'h10), 3'h0,
                         TAIL_BITS};
          end
          `LSM_FMT_12: begin
            next_word = {head_smp[8:1], 56'h0};
          end
          `LSM_FMT_13: begin
            next_word = {smp(src_ab, K),         1'b0,
                         smp(src_ab, K + 5'h04), 1'b0,
                         smp(src_ab, K + 5'h08), 1'b0,
                         smp(src_ab, K + 5'h0C), 1'b0, 24'h0};
          end
          `LSM_FMT_14: begin
            next_word = {smp(src_14, P14),         3'h0,
                         smp(src_14, P14 + 5'h02), 3'h0, 40'h0};
          end
          default: begin
            next_word = 64'h0;
          end
        endcase
        if (!next_lane_en[g]) begin
          next_word = 64'h0; // unused lanes stay quiet
        end
      end

      // hold the last frame between strobes
      // lanes that are off load zeros too, so stale data from a wider
      // setup stays on them only until the next frame is taken
      always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          word <= 64'h0;
        end else if (frame_take) begin
          word <= next_word;
        end
      end

      assign LANE_DATA_OUT[g * 64 +: 64] = word;
    end
  endgenerate

endmodule

/* File: core/lsm_consts.vh */
// constants for the sample-to-lane mapper: format codes, variants,
// lane masks, octets per lane frame and field sizes.
// assumes it is included by the mapper core only.
`ifndef LSM_CONSTS_VH
`define LSM_CONSTS_VH

// link format codes
`define LSM_FMT_11        4'hB
`define LSM_FMT_12        4'hC
`define LSM_FMT_13        4'hD
`define LSM_FMT_14        4'hE
`define LSM_FMT_RESET     4'hB

// device variants
`define LSM_VAR_SINGLE    2'h0
`define LSM_VAR_DUAL      2'h1
`define LSM_VAR_QUAD      2'h2
`define LSM_VAR_RESET     2'h1

// lane enable masks
`define LSM_MASK_8        8'hFF
`define LSM_MASK_4        8'h0F
`define LSM_MASK_2        8'h03
`define LSM_MASK_NONE     8'h00

// octets per lane frame
`define LSM_OCT_11        4'h8
`define LSM_OCT_12        4'h1
`define LSM_OCT_13        4'h5
`define LSM_OCT_14        4'h3

// field sizes
`define LSM_SMP_W         9
`define LSM_LANE_W        64
`define LSM_NUM_LANES     8
`define LSM_AB_BUS_W      180
`define LSM_CD_BUS_W      36

`endif

/* File: bench/lsm_rx_model.sv */
// receiver model: counts lane frames and unpacks lane 0 sample A0
// assumes it is set up with the same format as the mapper
`timescale 1ns/1ps
module lsm_rx_model (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire         valid_in,
  input  wire [3:0]   fmt_in,
  input  wire [511:0] data_in,
  output reg  [8:0]   a0_out,
  output reg  [15:0]  frames_out
);
  // takes each frame on the valid pulse
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a0_out <= 9'h000;
      frames_out <= 16'h0000;
    end else if (valid_in) begin
      frames_out <= frames_out + 16'h0001;
      a0_out <= (fmt_in == 4'hC) ? {data_in[63:56], 1'b0} : data_in[63:55];
    end
  end
endmodule

/* File: bench/lsm_lane_mapper_monitor.sv */
// checker for the lane mapper: frame timing, status fields, padding
// assumes it is bound to the mapper and sees its ports only
`timescale 1ns/1ps
module lsm_lane_mapper_monitor (
  input wire         SYS_CLK_IN,
  input wire         NRST_IN,
  input wire         LINK_EN_IN,
  input wire         FRAME_VALID_IN,
  input wire [511:0] LANE_DATA_OUT,
  input wire         LANE_VALID_OUT,
  input wire [7:0]   LANE_EN_OUT,
  input wire [3:0]   OCTETS_OUT,
  input wire         CODING_64B66B_OUT,
  input wire         CFG_ERROR_OUT,
  input wire [3:0]   FORMAT_ACTIVE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // frames and status
  a_frame_pulse: assert property (LANE_VALID_OUT == $past(FRAME_VALID_IN && LINK_EN_IN && !CFG_ERROR_OUT))
    else $error("bad valid");
  a_data_hold: assert property (!LANE_VALID_OUT |-> $stable(LANE_DATA_OUT)) else $error("data moved");
  a_fmt11_oct: assert property (!CFG_ERROR_OUT && FORMAT_ACTIVE_OUT == 4'hB |-> OCTETS_OUT == 4'h8 && !CODING_64B66B_OUT)
    else $error("fmt11 status");
  a_fmt12_oct: assert property (!CFG_ERROR_OUT && FORMAT_ACTIVE_OUT == 4'hC |-> OCTETS_OUT == 4'h1 && CODING_64B66B_OUT)
    else $error("fmt12 status");
  a_fmt13_oct: assert property (!CFG_ERROR_OUT && FORMAT_ACTIVE_OUT == 4'hD |-> OCTETS_OUT == 4'h5 && !CODING_64B66B_OUT)
    else $error("fmt13 status");
  a_fmt14_oct: assert property (!CFG_ERROR_OUT && FORMAT_ACTIVE_OUT == 4'hE |-> OCTETS_OUT == 4'h3 && CODING_64B66B_OUT)
    else $error("fmt14 status");
  a_cfg_frozen: assert property (LINK_EN_IN && $past(LINK_EN_IN) |-> $stable(FORMAT_ACTIVE_OUT) && $stable(LANE_EN_OUT))
    else $error("config moved");
  a_pad_zero: assert property (LANE_VALID_OUT && FORMAT_ACTIVE_OUT != 4'hB |-> LANE_DATA_OUT[23:0] == 24'h0)
    else $error("pad bits set");
  a_lane_off: assert property (LANE_VALID_OUT && !LANE_EN_OUT[7] |-> LANE_DATA_OUT[511:448] == 64'h0)
    else $error("off lane data");
  c_fmt11: cover property (LANE_VALID_OUT && FORMAT_ACTIVE_OUT == 4'hB);
  c_fmt14: cover property (LANE_VALID_OUT && FORMAT_ACTIVE_OUT == 4'hE);
  c_refused: cover property (FRAME_VALID_IN && CFG_ERROR_OUT);
endmodule
bind lsm_lane_mapper lsm_lane_mapper_monitor u_mon (.*);

/* File: bench/lsm_lane_mapper_tb.sv */
// bench for the lane mapper: format table, refusals, back-to-back frames
// assumes the mapper core and the receiver model are compiled with it
`timescale 1ns/1ps
module lsm_lane_mapper_tb;
  reg         clk = 0, nrst = 0, link = 0, fv = 0;
  reg [3:0]   fmt = 4'hB;
  reg [1:0]   vsel = 2'h1;
  reg [179:0] ch_a, ch_b;
  reg [35:0]  ch_c, ch_d;
  wire [511:0] ld;
  wire        lv, cod, err;
  wire [7:0]  en;
  wire [3:0]  oct, fa;
  wire [8:0]  rx_a0;
  wire [15:0] rx_n;
  integer     n_mismatch = 0, n_compared = 0, i, k;
  // rows: format, variant, lane mask, octets, coding
  reg [23:0]  rows [0:8] = '{24'hB00F80, 24'hB1FF80, 24'hC00F11, 24'hC1FF11, 24'hD00F50,
                             24'hD1FF50, 24'hE00331, 24'hE10F31, 24'hE2FF31};
  always #20 clk = ~clk;
  lsm_lane_mapper u_lsm_lane_mapper (.SYS_CLK_IN(clk), .NRST_IN(nrst), .FORMAT_SEL_IN(fmt), .VARIANT_IN(vsel),
    .LINK_EN_IN(link), .FRAME_VALID_IN(fv), .CHAN_A_IN(ch_a), .CHAN_B_IN(ch_b), .CHAN_C_IN(ch_c),
    .CHAN_D_IN(ch_d), .LANE_DATA_OUT(ld), .LANE_VALID_OUT(lv), .LANE_EN_OUT(en), .OCTETS_OUT(oct),
    .CODING_64B66B_OUT(cod), .CFG_ERROR_OUT(err), .FORMAT_ACTIVE_OUT(fa));
  lsm_rx_model u_lsm_rx_model (.clk_in(clk), .nrst_in(nrst), .valid_in(lv), .fmt_in(fmt), .data_in(ld),
    .a0_out(rx_a0), .frames_out(rx_n));
  function [8:0] smp(input integer c, input integer n);
    smp = (c == 0 ? 9'h1A0 : c == 1 ? 9'h0C0 : c == 2 ? 9'h150 : 9'h0F0) + n;
  endfunction
  // expected lane k contents for format f
  function [63:0] lane(input [3:0] f, input integer k);
    integer c, j;
    begin
      c = (f == 4'hE) ? k / 2 : k / 4;
      j = (f == 4'hE) ? k % 2 : k % 4;
      case (f)
        4'hB: lane = {smp(c,j),3'h0,smp(c,j+4),3'h0,smp(c,j+8),3'h0,smp(c,j+12),3'h0,smp(c,j+16),3'h0,4'h0};
        4'hC: lane = {smp(c,j),55'h0} & 64'hFF00000000000000;
        4'hD: lane = {smp(c,j),1'b0,smp(c,j+4),1'b0,smp(c,j+8),1'b0,smp(c,j+12),1'b0,24'h0};
        default: lane = {smp(c,j),3'h0,smp(c,j+2),3'h0,40'h0};
      endcase
    end
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task send;
    begin
      @(negedge clk) fv = 1;
      @(negedge clk) fv = 0;
    end
  endtask
  task results;
    begin
      $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #10000 n_mismatch = n_mismatch + 1;
    results;
  end
  initial begin
    for (i = 0; i < 20; i = i + 1) begin
      ch_a[i*9 +: 9] = smp(0, i);
      ch_b[i*9 +: 9] = smp(1, i);
      if (i < 4) {ch_c[i*9 +: 9], ch_d[i*9 +: 9]} = {smp(2, i), smp(3, i)};
    end
    repeat (3) @(negedge clk);
    chk({en, oct, fa}, 16'h008B);
    nrst = 1;
    for (i = 0; i < 9; i = i + 1) begin
      {fmt, vsel, link} = {rows[i][23:20], rows[i][17:16], 1'b0};
      repeat (3) @(negedge clk);
      link = 1; // setup steady three edges before the link rises
      chk({en, oct, 3'h0, cod}, rows[i][15:0]);
      send;
      chk(lv, 1);
      for (k = 0; k < 8; k = k + 1)
        chk(ld[k*64 +: 64], rows[i][8+k] ? lane(rows[i][23:20], k) : 64'h0);
      @(negedge clk) chk(rx_a0, 9'h1A0);
    end
    fmt = 4'hB;
    repeat (3) @(negedge clk);
    chk(fa, 4'hE);
    link = 0;
    send;
    chk({lv, err}, 2'h1);
    link = 1;
    send;
    chk(lv, 0);
    {fmt, vsel, link} = {4'hD, 2'h1, 1'b0};
    repeat (3) @(negedge clk);
    link = 1;
    fv = 1;
    repeat (2) @(negedge clk) chk(lv, 1);
    fv = 0;
    @(negedge clk) chk({lv, rx_n}, 17'd11);
    results;
  end
endmodule
